/* File: common/tpfc_pkg.sv */
// package of constants and types for the transmit pause flow control unit
`default_nettype none
package tpfc_pkg;
    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int unsigned NUM_QUEUES = 8;
    localparam int unsigned QIDX_W = 3;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned QUANTA_W = 16;
    // ---------------------------------------------------------------
    // register offsets (word index)
    // ---------------------------------------------------------------
    localparam logic [11:0] OFF_REVISION = 12'h600;
    localparam logic [11:0] OFF_SCRATCH = 12'h601;
    localparam logic [11:0] OFF_STRING0 = 12'h602;
    localparam logic [11:0] OFF_STRING1 = 12'h603;
    localparam logic [11:0] OFF_STRING2 = 12'h604;
    localparam logic [11:0] OFF_PAUSE_EN = 12'h605;
    localparam logic [11:0] OFF_PAUSE_REQ = 12'h606;
    localparam logic [11:0] OFF_RESEND_EN = 12'h607;
    localparam logic [11:0] OFF_RESEND_INTERVAL = 12'h608;
    localparam logic [11:0] OFF_PAUSE_QUANTA = 12'h609;
    localparam logic [11:0] OFF_QUEUE_INDEX = 12'h60a;
    // ---------------------------------------------------------------
    // reset values and identity (identity values are arbitrary)
    // ---------------------------------------------------------------
    localparam logic [31:0] REVISION_VALUE = 32'h0000_0001;
    localparam logic [31:0] STRING_WORD0 = 32'h5446_4354;
    localparam logic [31:0] STRING_WORD1 = 32'h524c_5f50;
    localparam logic [31:0] STRING_WORD2 = 32'h4155_5345;
    localparam logic [31:0] SCRATCH_RESET = 32'h0000_0000;
    localparam logic [7:0] PAUSE_EN_RESET = 8'hff;
    localparam logic [7:0] PAUSE_REQ_RESET = 8'h00;
    localparam logic [7:0] RESEND_EN_RESET = 8'hff;
    localparam logic [15:0] QUANTA_RESET = 16'hffff;
    // ---------------------------------------------------------------
    // timing: one quantum is 512 bit times; datapath bits per clock
    // ---------------------------------------------------------------
    localparam int unsigned QUANTUM_BITS = 512;
    localparam int unsigned DATAPATH_BITS = 512;
    localparam int unsigned QUANTUM_CYCLES = (QUANTUM_BITS + DATAPATH_BITS - 1) / DATAPATH_BITS;
    localparam logic [8:0] QUANTUM_LAST = 9'(QUANTUM_CYCLES - 1);
    // ---------------------------------------------------------------
    // frame request to the transmit datapath
    // ---------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic xon;
        logic [2:0] queue;
        logic [15:0] quanta;
    } tpfc_frame_s;
endpackage
`default_nettype wire

/* File: hdl/tpfc_top.sv */
// transmit pause flow control unit: registers, queue tables, frame scheduler
//
// Overview of operation
// - interval and quanta registers show the table entry picked by queue index.
// - read-only 32-bit revision register at the first offset.
// - read-write 32-bit scratch register, no effect, resets to zero.
// - three read-only words give the variant string, first characters in the high byte of the lowest word.
// - pause frames go out only when enabled; request from pin or register.
// - each enable bit gates pause for its own queue.
// - enable, request and resend-enable fields are one bit per queue; interval and quanta are 16 bits per queue.
// - request rising with enable set inserts an XOFF frame; request resets zero.
// - with resend enabled, XOFF repeats every interval while request stays high.
// - request falling with enable set inserts an XON frame.
// - intervals and durations count quanta of 512 bit times.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module tpfc_top
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // client pause request, one bit per queue, same clock
    input wire logic [7:0] pause_req_i,
    // pause frame request to the transmit datapath
    output tpfc_pkg::tpfc_frame_s frame_o,
    input wire logic frame_ack_i
);
    // ---------------------------------------------------------------
    // register file
    // ---------------------------------------------------------------
    logic [31:0] scratch_q;
    logic [7:0] pause_en_q;
    logic [7:0] req_reg_q;
    logic [7:0] resend_en_q;
    logic [2:0] qidx_q;
    logic [15:0] interval_tab [0:7];
    logic [15:0] quanta_tab [0:7];
    logic [31:0] rdata_q;

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    // true when a strobe hits the given register offset
    function automatic logic tpfc_hit(input logic strobe, input logic [11:0] addr,
        input logic [11:0] offset);
        return strobe && addr == offset;
    endfunction

    wire wr_scratch = tpfc_hit(wr_i, addr_i, tpfc_pkg::OFF_SCRATCH);
    wire wr_en = tpfc_hit(wr_i, addr_i, tpfc_pkg::OFF_PAUSE_EN);
    wire wr_req = tpfc_hit(wr_i, addr_i, tpfc_pkg::OFF_PAUSE_REQ);
    wire wr_resend = tpfc_hit(wr_i, addr_i, tpfc_pkg::OFF_RESEND_EN);
    wire wr_interval = tpfc_hit(wr_i, addr_i, tpfc_pkg::OFF_RESEND_INTERVAL);
    wire wr_quanta = tpfc_hit(wr_i, addr_i, tpfc_pkg::OFF_PAUSE_QUANTA);
    wire wr_qidx = tpfc_hit(wr_i, addr_i, tpfc_pkg::OFF_QUEUE_INDEX);

    logic [31:0] rd_mux;
    always_comb
    begin
        unique case (addr_i)
            tpfc_pkg::OFF_REVISION: rd_mux = tpfc_pkg::REVISION_VALUE;
            tpfc_pkg::OFF_SCRATCH: rd_mux = scratch_q;
            tpfc_pkg::OFF_STRING0: rd_mux = tpfc_pkg::STRING_WORD0;
            tpfc_pkg::OFF_STRING1: rd_mux = tpfc_pkg::STRING_WORD1;
            tpfc_pkg::OFF_STRING2: rd_mux = tpfc_pkg::STRING_WORD2;
            tpfc_pkg::OFF_PAUSE_EN: rd_mux = {24'h000000, pause_en_q};
            tpfc_pkg::OFF_PAUSE_REQ: rd_mux = {24'h000000, req_reg_q};
            tpfc_pkg::OFF_RESEND_EN: rd_mux = {24'h000000, resend_en_q};
            tpfc_pkg::OFF_RESEND_INTERVAL: rd_mux = {16'h0000, interval_tab[qidx_q]};
            tpfc_pkg::OFF_PAUSE_QUANTA: rd_mux = {16'h0000, quanta_tab[qidx_q]};
            tpfc_pkg::OFF_QUEUE_INDEX: rd_mux = {29'h0, qidx_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // scratch word, no effect on the unit
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            scratch_q <= tpfc_pkg::SCRATCH_RESET;
        else if (wr_scratch)
            scratch_q <= wdata_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            pause_en_q <= tpfc_pkg::PAUSE_EN_RESET;
        else if (wr_en)
            pause_en_q <= wdata_i[7:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            req_reg_q <= tpfc_pkg::PAUSE_REQ_RESET;
        else if (wr_req)
            req_reg_q <= wdata_i[7:0];
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            resend_en_q <= tpfc_pkg::RESEND_EN_RESET;
        else if (wr_resend)
            resend_en_q <= wdata_i[7:0];
    end

    // table index for the interval and quanta windows
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            qidx_q <= 3'h0;
        else if (wr_qidx)
            qidx_q <= wdata_i[2:0];
    end

    // read data stands one cycle, zero otherwise
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            rdata_q <= 32'h0000_0000;
        else
            rdata_q <= rd_i ? rd_mux : 32'h0000_0000;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            for (int i = 0; i < 8; i++)
            begin
                interval_tab[i] <= tpfc_pkg::QUANTA_RESET;
                quanta_tab[i] <= tpfc_pkg::QUANTA_RESET;
            end
        end
        else
        begin
            if (wr_interval)
                interval_tab[qidx_q] <= wdata_i[15:0];
            if (wr_quanta)
                quanta_tab[qidx_q] <= wdata_i[15:0];
        end
    end

    assign rdata_o = rdata_q;

    // ---------------------------------------------------------------
    // quantum tick: one enable pulse per 512 bit times
    // ---------------------------------------------------------------
    logic [8:0] qdiv_q;
    logic tick_q;
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= qdiv_q == tpfc_pkg::QUANTUM_LAST;
        end
    end

    // divider toward the quantum boundary
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            qdiv_q <= 9'h000;
        else
            qdiv_q <= (qdiv_q == tpfc_pkg::QUANTUM_LAST) ? 9'h000 : qdiv_q + 9'h001;
    end

    // ---------------------------------------------------------------
    // per-queue request tracking and pending frames
    // ---------------------------------------------------------------
    wire [7:0] req_now = pause_req_i | req_reg_q;
    logic [7:0] req_prev_q;
    logic [7:0] xoff_pend_q;
    logic [7:0] xon_pend_q;
    logic [15:0] timer_q [0:7];
    logic [7:0] timer_run_q;
    tpfc_pkg::tpfc_frame_s frame_q;

    wire [7:0] rise = req_now & ~req_prev_q & pause_en_q;
    wire [7:0] fall = ~req_now & req_prev_q & pause_en_q;
    logic [7:0] expire;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            expire[i] = timer_run_q[i] && tick_q && timer_q[i] == 16'h0000
                && req_now[i] && resend_en_q[i] && pause_en_q[i];
    end

    // ---------------------------------------------------------------
    // frame selection
    // ---------------------------------------------------------------
    // lowest-numbered pending queue is served first
    function automatic logic [2:0] tpfc_lowest(input logic [7:0] bits);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = 7; i >= 0; i--)
            if (bits[i])
                idx = 3'(i);
        return idx;
    endfunction

    wire [7:0] pend = xoff_pend_q | xon_pend_q;
    wire [2:0] pick = tpfc_lowest(pend);
    wire launch = (pend != 8'h00) && (!frame_q.valid || frame_ack_i);
    wire [7:0] sent = launch ? (8'h01 << pick) : 8'h00;
    wire launch_xoff = launch && xoff_pend_q[pick];
    wire launch_xon = !xoff_pend_q[pick];
    wire [15:0] launch_quanta = xoff_pend_q[pick] ? quanta_tab[pick] : 16'h0000;

    // ---------------------------------------------------------------
    // request edges and pending flags
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            req_prev_q <= 8'h00;
        else
            req_prev_q <= req_now;
    end

    // a new event wins over the launch that clears its flag
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            xoff_pend_q <= 8'h00;
        else
            xoff_pend_q <= (xoff_pend_q & ~sent & ~fall) | rise | expire;
    end

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            xon_pend_q <= 8'h00;
        else
            xon_pend_q <= (xon_pend_q & ~sent & ~rise) | fall;
    end

    // ---------------------------------------------------------------
    // resend timers
    // ---------------------------------------------------------------

    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            timer_run_q <= 8'h00;
            for (int i = 0; i < 8; i++)
                timer_q[i] <= 16'h0000;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (launch_xoff && pick == 3'(i))
                begin
                    timer_run_q[i] <= 1'b1;
                    timer_q[i] <= interval_tab[i];
                end
                else if (!req_now[i] || expire[i])
                    timer_run_q[i] <= 1'b0;
                else if (tick_q && timer_q[i] != 16'h0000)
                    timer_q[i] <= timer_q[i] - 16'h0001;
            end
        end
    end

    // ---------------------------------------------------------------
    // frame output, held until the datapath accepts it
    // ---------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            frame_q <= '0;
        else if (launch)
        begin
            frame_q.valid <= 1'b1;
            frame_q.xon <= launch_xon;
            frame_q.queue <= pick;
            frame_q.quanta <= launch_quanta;
        end
        else if (frame_ack_i)
            frame_q.valid <= 1'b0;
    end

    assign frame_o = frame_q;
endmodule
`default_nettype wire

/* File: testbench/tpfc_assertions.sv */
// port assertions for the transmit pause flow control unit
`timescale 1ns/1ps
`default_nettype none
module tpfc_assertions
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // register port
    input wire logic [11:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    // pause request and frame port
    input wire logic [7:0] pause_req_i,
    input wire tpfc_pkg::tpfc_frame_s frame_o,
    input wire logic frame_ack_i
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    a_revision_read: assert property (
        rd_i && addr_i == tpfc_pkg::OFF_REVISION |=> rdata_o == tpfc_pkg::REVISION_VALUE)
        else $error("revision read wrong");
    a_string_first: assert property (
        rd_i && addr_i == tpfc_pkg::OFF_STRING0 |=> rdata_o == tpfc_pkg::STRING_WORD0)
        else $error("first string word wrong");
    a_scratch_readback: assert property (
        wr_i && addr_i == tpfc_pkg::OFF_SCRATCH ##1 rd_i && addr_i == tpfc_pkg::OFF_SCRATCH
        |=> rdata_o == $past(wdata_i, 2))
        else $error("scratch read back wrong");
    a_unmapped_zero: assert property (
        rd_i && addr_i > tpfc_pkg::OFF_QUEUE_INDEX |=> rdata_o == 32'h0)
        else $error("unmapped read not zero");
    a_enable_width: assert property (
        rd_i && addr_i == tpfc_pkg::OFF_PAUSE_EN |=> rdata_o[31:8] == 24'h0)
        else $error("enable upper bits not zero");
    a_reset_clear: assert property (
        $past(rst_i) |-> frame_o == 21'h0 && rdata_o == 32'h0)
        else $error("outputs not clear after reset");
    a_frame_hold: assert property (
        frame_o.valid && !frame_ack_i |=> $stable(frame_o))
        else $error("frame changed before accept");
    a_xon_quanta: assert property (
        frame_o.valid && frame_o.xon |-> frame_o.quanta == 16'h0)
        else $error("resume frame quanta not zero");
endmodule
bind tpfc_top tpfc_assertions u_tpfc_assertions (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pause_req_i(pause_req_i), .frame_o(frame_o), .frame_ack_i(frame_ack_i));
`default_nettype wire

/* File: testbench/tpfc_sink.sv */
// datapath model that accepts pause frames and can stall
`timescale 1ns/1ps
`default_nettype none
module tpfc_sink
(
    // clock
    input wire logic clock_i,
    // frame port
    input wire tpfc_pkg::tpfc_frame_s frame_i,
    output logic frame_ack_o,
    // stall control
    input wire logic stall_i
);
    tpfc_pkg::tpfc_frame_s log_q[$];
    assign frame_ack_o = !stall_i;
    always @(posedge clock_i)
    begin
        if (frame_i.valid && frame_ack_o)
        begin
            log_q.push_back(frame_i);
        end
    end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking bench for the transmit pause flow control unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [7:0] pause_req = 8'h0;
    logic stall = 1'b0;
    logic ack;
    tpfc_pkg::tpfc_frame_s frame;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;
    always #2 clock_i = ~clock_i;
    tpfc_top u_tpfc_top (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .pause_req_i(pause_req), .frame_o(frame),
        .frame_ack_i(ack));
    tpfc_sink u_tpfc_sink (.clock_i(clock_i), .frame_i(frame), .frame_ack_o(ack),
        .stall_i(stall));
    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic print_verdict();
        if (fails == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d);
        wr <= w;
        rd <= r;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        #1;
    endtask
    task automatic idle(input int k);
        repeat (k) bus(1'b0, 1'b0, addr, wdata);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, 1'b1, a, wdata);
        check($sformatf("reg %h", a), rdata, exp);
    endtask
    task automatic fchk(input int i, input logic x, input logic [2:0] q, input logic [15:0] qt);
        check($sformatf("frame %0d", i), {11'h0, u_tpfc_sink.log_q[i]}, {11'h0, 1'b1, x, q, qt});
    endtask
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            print_verdict();
        end
    end
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        #1;
        rdchk(12'h600, tpfc_pkg::REVISION_VALUE);
        rdchk(12'h602, tpfc_pkg::STRING_WORD0);
        rdchk(12'h603, tpfc_pkg::STRING_WORD1);
        rdchk(12'h604, tpfc_pkg::STRING_WORD2);
        rdchk(12'h601, 32'h0);
        rdchk(12'h605, 32'hff);
        rdchk(12'h606, 32'h0);
        rdchk(12'h60b, 32'h0);
        bus(1'b1, 1'b0, 12'h601, 32'ha5c3_0f96);
        rdchk(12'h601, 32'ha5c3_0f96);
        bus(1'b1, 1'b0, 12'h600, 32'h1234_5678);
        rdchk(12'h600, tpfc_pkg::REVISION_VALUE);
        bus(1'b1, 1'b0, 12'h60a, 32'h2);
        bus(1'b1, 1'b0, 12'h608, 32'h10);
        bus(1'b1, 1'b0, 12'h609, 32'h123);
        bus(1'b1, 1'b0, 12'h60a, 32'h5);
        bus(1'b1, 1'b0, 12'h609, 32'h456);
        rdchk(12'h608, 32'hffff);
        bus(1'b1, 1'b0, 12'h60a, 32'h2);
        rdchk(12'h609, 32'h123);
        rdchk(12'h608, 32'h10);
        // client pin path, datapath stalled at first
        stall <= 1'b1;
        pause_req[2] <= 1'b1;
        idle(6);
        check("held frame", {11'h0, frame}, {11'h0, 1'b1, 1'b0, 3'h2, 16'h123});
        stall <= 1'b0;
        idle(40);
        pause_req[2] <= 1'b0;
        idle(10);
        n = u_tpfc_sink.log_q.size();
        fchk(0, 1'b0, 3'h2, 16'h123);
        fchk(1, 1'b0, 3'h2, 16'h123);
        check("resend count", 32'(n >= 4), 32'h1);
        fchk(n - 1, 1'b1, 3'h2, 16'h0);
        // register path with queue 2 disabled
        bus(1'b1, 1'b0, 12'h605, 32'hfb);
        bus(1'b1, 1'b0, 12'h606, 32'h04);
        idle(8);
        check("disabled queue", u_tpfc_sink.log_q.size(), n);
        rdchk(12'h606, 32'h04);
        bus(1'b1, 1'b0, 12'h606, 32'h06);
        idle(8);
        bus(1'b1, 1'b0, 12'h606, 32'h04);
        idle(8);
        fchk(n, 1'b0, 3'h1, 16'hffff);
        fchk(n + 1, 1'b1, 3'h1, 16'h0);
        check("frame count", u_tpfc_sink.log_q.size(), n + 2);
        print_verdict();
    end
endmodule
`default_nettype wire
